// [paged_data_window_address_extension.sv]
// Purpose: Paged data window address extension between address generator and data memory.
// Assumes: One access request per cycle from logic on core_clk; register port on the same clock.
// Notes:   Corrected access, page and trap leave one cycle after the request is taken.
//
// Contract
// - Separate read and write page selectors
// - Read one page, write another, one instruction
// - Crossing calculation clears window address bit
// - Crossing needs window start and pre/post mode
// - Overflow increments selector, sets window bit
// - Underflow decrements selector, sets window bit
// - Offset, modulo, bit-reversed wrap within page
// - Overflow from last extended page enters base
// - Read overflow 0x2FF advances to 0x300
// - Read overflow 0x3FF stays, enters base
// - Read underflow 0x001 stays, enters base
// - Read underflow 0x200 stays, enters base
// - Read underflow 0x300 steps to 0x2FF
// - Cleared window bit targets base data space
// - Window access with page 0 traps
// - Writes into program space trap
`timescale 1ns/100ps
module paged_data_window_address_extension
   import paged_window_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Access request from the address generator
   input wire logic acc_req,
   input wire logic acc_is_write,
   input wire addr_mode_t acc_mode,
   input wire logic [15:0] acc_base_ea,
   input wire logic [15:0] acc_offset,
   // Corrected access toward data memory
   output logic mem_valid,
   output logic mem_write,
   output logic [15:0] mem_effective_address,
   output logic [9:0] mem_page,
   output space_t mem_space,
   // Exception request toward the core
   output logic addr_error_trap
);

   // ==========================================================================
   // State

   // Everything the block remembers, registered as one word
   typedef struct packed {
      logic [9:0] rd_sel;          // Read page selector
      logic [9:0] wr_sel;          // Write page selector
      logic out_valid;             // Issued access
      logic out_write;             // Issued access is a write
      logic [15:0] out_ea;         // Issued effective address
      logic [9:0] out_page;        // Page that goes with it
      space_t out_space;           // Space that goes with it
      logic trap;                  // Address error pulse
      logic [15:0] rdata;          // Register read answer
      logic sticky_page0;          // Page 0 trap seen
      logic sticky_ps_write;       // Program space write trap seen
      logic last_ovf;              // Last taken access overflowed
      logic last_unf;              // Last taken access underflowed
   } state_t;

   state_t state_reg;              // Current state
   state_t state_next;             // Next state
   logic [9:0] used_sel;           // Selector of the current direction
   logic trap_now;                 // Current request traps
   logic [15:0] status_word;       // Status register as read

   // Boundary unit request and answer
   window_adjust_if adj_if ();

   // ==========================================================================
   // Boundary unit

   // The read selector serves reads and the write selector serves writes
   assign used_sel = acc_is_write ? state_reg.wr_sel : state_reg.rd_sel;

   // Request side of the boundary unit
   assign adj_if.pre_ea = acc_base_ea;
   assign adj_if.offset = acc_offset;
   assign adj_if.mode = acc_mode;
   assign adj_if.is_write = acc_is_write;
   assign adj_if.sel = used_sel;

   // Crossing correction lives in its own unit so that its rules read in one place
   window_boundary_unit u_boundary (
      .port_if(adj_if.unit)
   );

   // Either trap cause on a taken request
   assign trap_now = acc_req && (adj_if.trap_page0 || adj_if.trap_ps_write);

   // Status word as software sees it; upper bits read as zero
   always_comb begin
      status_word = 16'h0000;
      status_word[ST_PAGE0] = state_reg.sticky_page0;
      status_word[ST_PSWRITE] = state_reg.sticky_ps_write;
      status_word[ST_OVF] = state_reg.last_ovf;
      status_word[ST_UNF] = state_reg.last_unf;
   end

   // ==========================================================================
   // Next state

   // All state changes are worked out here and registered below
   always_comb begin
      state_next = state_reg;

      // Access side: one result per request, held off when nothing is requested
      state_next.out_valid = 1'b0;
      state_next.trap = 1'b0;
      if (acc_req) begin
         // A trapped access never reaches memory, so a bad write cannot land
         state_next.out_valid = !trap_now;
         state_next.out_write = acc_is_write;
         state_next.out_ea = adj_if.ea;
         state_next.out_page = adj_if.sel_next;
         state_next.out_space = adj_if.space;
         // Pulse follows trap_now every cycle, so back-to-back trapping requests hold it high
         state_next.trap = trap_now;
         state_next.last_ovf = adj_if.ovf;
         state_next.last_unf = adj_if.unf;
         // Only the selector of this direction follows a page step
         if (!trap_now) begin
            if (acc_is_write) begin
               state_next.wr_sel = adj_if.sel_next;
            end else begin
               state_next.rd_sel = adj_if.sel_next;
            end
         end
      end

      // Software selector writes take precedence over a same-cycle page step,
      // so a reprogrammed page is never overwritten by a stale increment
      if (reg_wr) begin
         unique case (reg_addr)
            REG_RD_SEL: begin
               // Read page may point at extended or program space independently
               state_next.rd_sel = reg_wdata[9:0];
            end
            REG_WR_SEL: begin
               // Write page is kept apart so page-to-page moves need no reload
               state_next.wr_sel = reg_wdata[9:0];
            end
            REG_STATUS: begin
               // Write one to clear the sticky causes
               if (reg_wdata[ST_PAGE0]) begin
                  state_next.sticky_page0 = 1'b0;
               end
               if (reg_wdata[ST_PSWRITE]) begin
                  state_next.sticky_ps_write = 1'b0;
               end
            end
            REG_LAST_EA: begin
               // Read-only; write has no effect
            end
         endcase
      end

      // A trap arriving with a clear keeps its flag set
      if (acc_req && adj_if.trap_page0) begin
         state_next.sticky_page0 = 1'b1;
      end
      if (acc_req && adj_if.trap_ps_write) begin
         state_next.sticky_ps_write = 1'b1;
      end

      // Read answer stands for the one cycle after the strobe only
      state_next.rdata = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_RD_SEL: begin
               state_next.rdata = {6'h00, state_reg.rd_sel};
            end
            REG_WR_SEL: begin
               state_next.rdata = {6'h00, state_reg.wr_sel};
            end
            REG_STATUS: begin
               state_next.rdata = status_word;
            end
            REG_LAST_EA: begin
               state_next.rdata = state_reg.out_ea;
            end
         endcase
      end
   end

   // ==========================================================================
   // State register

   // Synchronous reset puts both selectors on the first extended page,
   // which is a legal page, so an early window access does not trap
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg.rd_sel <= SEL_RESET;
         state_reg.wr_sel <= SEL_RESET;
         state_reg.out_valid <= 1'b0;
         state_reg.out_write <= 1'b0;
         state_reg.out_ea <= 16'h0000;
         state_reg.out_page <= SEL_RESET;
         state_reg.out_space <= SPACE_BASE;
         state_reg.trap <= 1'b0;
         state_reg.rdata <= 16'h0000;
         state_reg.sticky_page0 <= 1'b0;
         state_reg.sticky_ps_write <= 1'b0;
         state_reg.last_ovf <= 1'b0;
         state_reg.last_unf <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================================
   // Outputs, all straight from the state register

   assign reg_rdata = state_reg.rdata;
   assign mem_valid = state_reg.out_valid;
   assign mem_write = state_reg.out_write;
   assign mem_effective_address = state_reg.out_ea;
   assign mem_page = state_reg.out_page;
   assign mem_space = state_reg.out_space;
   assign addr_error_trap = state_reg.trap;

endmodule

// [paged_window_pkg.sv]
// Purpose: Shared constants and types for the paged data window address extension.
// Assumes: 16-bit effective addresses, 10-bit page selectors, one core clock.
// Notes:   Register offsets are referenced by name only; the bench gives selector values as literals.
package paged_window_pkg;

   // ==========================================================================
   // Widths
   localparam int unsigned EA_W = 16;               // Effective address width
   localparam int unsigned SEL_W = 10;              // Page selector width
   localparam int unsigned REG_ADDR_W = 2;          // Register port address width
   localparam int unsigned REG_DATA_W = 16;         // Register port data width

   // ==========================================================================
   // Page selector landmarks
   localparam logic [9:0] SEL_INVALID = 10'h000;    // Page 0, traps in the window
   localparam logic [9:0] SEL_EDS_FIRST = 10'h001;  // First extended data page
   localparam logic [9:0] SEL_EDS_LAST = 10'h1FF;   // Last extended data page
   localparam logic [9:0] SEL_LSW_FIRST = 10'h200;  // First program lower-word page
   localparam logic [9:0] SEL_LSW_LAST = 10'h2FF;   // Last program lower-word page
   localparam logic [9:0] SEL_MSB_FIRST = 10'h300;  // First program upper-byte page
   localparam logic [9:0] SEL_MSB_LAST = 10'h3FF;   // Last program upper-byte page
   localparam logic [9:0] SEL_RESET = 10'h001;      // Selector value after reset
   localparam int unsigned WINDOW_BIT = 15;         // Address bit that opens the window

   // ==========================================================================
   // Register offsets and status bit positions
   localparam logic [1:0] REG_RD_SEL = 2'h0;        // Read page selector
   localparam logic [1:0] REG_WR_SEL = 2'h1;        // Write page selector
   localparam logic [1:0] REG_STATUS = 2'h2;        // Sticky trap causes, last crossing
   localparam logic [1:0] REG_LAST_EA = 2'h3;       // Last issued effective address
   localparam int unsigned ST_PAGE0 = 0;            // Window access with selector 0
   localparam int unsigned ST_PSWRITE = 1;          // Write toward program space
   localparam int unsigned ST_OVF = 2;              // Last access overflowed a page
   localparam int unsigned ST_UNF = 3;              // Last access underflowed a page

   // ==========================================================================
   // Addressing modes of the requesting address generator
   typedef enum logic [2:0] {
      MODE_PRE_MOD = 3'h0,
      MODE_POST_MOD = 3'h1,
      MODE_REG_OFFSET = 3'h2,
      MODE_MODULO = 3'h3,
      MODE_BIT_REV = 3'h4,
      MODE_DIRECT = 3'h5
   } addr_mode_t;

   // Target space of an issued access
   typedef enum logic [1:0] {
      SPACE_BASE = 2'h0,
      SPACE_EXT = 2'h1,
      SPACE_PROG = 2'h2
   } space_t;

   // Program-visible pages carry the top selector bit
   function automatic logic is_prog_page(input logic [9:0] sel);
      is_prog_page = sel[SEL_W-1];
   endfunction

endpackage

// [window_adjust_if.sv]
// Purpose: Carries one access request to the boundary unit and its answer back.
// Assumes: Purely combinational path inside one clock cycle.
// Notes:   The top drives the request side and reads the answer side.
`timescale 1ns/100ps
interface window_adjust_if;
   import paged_window_pkg::*;
   logic [15:0] pre_ea;      // Address before modification
   logic [15:0] offset;      // Signed modification amount
   addr_mode_t mode;         // Addressing mode
   logic is_write;           // Access direction
   logic [9:0] sel;          // Selector of that direction
   logic [15:0] ea;          // Corrected effective address
   logic [9:0] sel_next;     // Selector after the access
   logic ovf;                // Page overflow seen
   logic unf;                // Page underflow seen
   logic trap_page0;         // Window access with selector 0
   logic trap_ps_write;      // Write into program space
   space_t space;            // Space the access lands in
   modport unit (input pre_ea, offset, mode, is_write, sel,
                 output ea, sel_next, ovf, unf, trap_page0, trap_ps_write, space);
   modport client (output pre_ea, offset, mode, is_write, sel,
                   input ea, sel_next, ovf, unf, trap_page0, trap_ps_write, space);
endinterface

// [window_boundary_unit.sv]
// Purpose: Page crossing detection and boundary correction for one access.
// Assumes: Selector given is the one matching the access direction.
// Notes:   Combinational; the caller registers the result.
`timescale 1ns/100ps
module window_boundary_unit
   import paged_window_pkg::*;
(
   window_adjust_if.unit port_if
);

   logic [16:0] sum;   // Address plus sign-extended offset, with carry
   logic linear;       // Mode walks pages linearly
   logic wrapping;     // Mode wraps inside the current page

   // ==========================================================================
   // Crossing detection and correction
   always_comb begin
      sum = {1'b0, port_if.pre_ea} + {port_if.offset[15], port_if.offset};
      linear = (port_if.mode == MODE_PRE_MOD) || (port_if.mode == MODE_POST_MOD);
      wrapping = (port_if.mode == MODE_REG_OFFSET) || (port_if.mode == MODE_MODULO) ||
                 (port_if.mode == MODE_BIT_REV);
      // Crossing only counts when the start address lies in the window
      port_if.ovf = port_if.pre_ea[WINDOW_BIT] && sum[16] && (linear || wrapping);
      port_if.unf = port_if.pre_ea[WINDOW_BIT] && !sum[16] && !sum[WINDOW_BIT] &&
                    (linear || wrapping);
      // Raw result already has the window bit cleared on a crossing
      port_if.ea = sum[15:0];
      port_if.sel_next = port_if.sel;
      if (port_if.ovf && linear) begin
         if ((port_if.sel == SEL_EDS_LAST) || (port_if.sel == SEL_MSB_LAST)) begin
            // Top of a space: stay on the page and drop into base data space
            port_if.ea[WINDOW_BIT] = 1'b0;
         end else begin
            // Includes the lower-word to upper-byte step from the last lsw page
            port_if.sel_next = port_if.sel + 10'h001;
            port_if.ea[WINDOW_BIT] = 1'b1;
         end
      end else if (port_if.unf && linear) begin
         if ((port_if.sel == SEL_EDS_FIRST) || (port_if.sel == SEL_LSW_FIRST)) begin
            // Bottom of a space: stay on the page and drop into base data space
            port_if.ea[WINDOW_BIT] = 1'b0;
         end else begin
            // Includes the upper-byte to lower-word step back to the last lsw page
            port_if.sel_next = port_if.sel - 10'h001;
            port_if.ea[WINDOW_BIT] = 1'b1;
         end
      end else if (port_if.ovf || port_if.unf) begin
         // Wrap around inside the current page with the window bit set, selector untouched
         port_if.ea[WINDOW_BIT] = 1'b1;
      end
      // Traps judge the page the access really lands on
      port_if.trap_page0 = port_if.ea[WINDOW_BIT] && (port_if.sel_next == SEL_INVALID);
      port_if.trap_ps_write = port_if.ea[WINDOW_BIT] && port_if.is_write &&
                              is_prog_page(port_if.sel_next);
      if (!port_if.ea[WINDOW_BIT]) begin
         port_if.space = SPACE_BASE;
      end else if (is_prog_page(port_if.sel_next)) begin
         port_if.space = SPACE_PROG;
      end else begin
         port_if.space = SPACE_EXT;
      end
   end

endmodule

// [paged_window_props.sv]
// Purpose: Concurrent checks on the ports of the paged data window block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Selectors are internal, so checks tie outputs to request inputs.
`timescale 1ns/100ps
module paged_window_props
   import paged_window_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic acc_req,
   input wire logic acc_is_write,
   input wire addr_mode_t acc_mode,
   input wire logic [15:0] acc_base_ea,
   input wire logic [15:0] acc_offset,
   input wire logic mem_valid,
   input wire logic mem_write,
   input wire logic [15:0] mem_effective_address,
   input wire logic [9:0] mem_page,
   input wire space_t mem_space,
   input wire logic addr_error_trap
);
   // ==========================================================================
   // Helper: raw modified address, before any boundary correction
   logic [15:0] sum16; // Low 15 bits never change by correction
   assign sum16 = acc_base_ea + acc_offset;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================================
   // Properties
   property p_valid_cause; mem_valid |-> $past(acc_req); endproperty
   a_valid_cause: assert property (p_valid_cause) else $error("issued access without request");
   property p_trap_cause; addr_error_trap |-> $past(acc_req) && !mem_valid; endproperty
   a_trap_cause: assert property (p_trap_cause) else $error("trap not tied to one request");
   property p_answer; acc_req |=> mem_valid || addr_error_trap; endproperty
   a_answer: assert property (p_answer) else $error("request not answered next cycle");
   property p_dir; mem_valid |-> mem_write == $past(acc_is_write); endproperty
   a_dir: assert property (p_dir) else $error("issued direction differs");
   property p_low_bits; mem_valid |-> mem_effective_address[14:0] == $past(sum16[14:0]); endproperty
   a_low_bits: assert property (p_low_bits) else $error("page offset bits wrong");
   property p_base_pre; mem_valid && !$past(acc_base_ea[15]) |-> mem_effective_address == $past(sum16); endproperty
   a_base_pre: assert property (p_base_pre) else $error("crossing from base space");
   property p_wrap;
      mem_valid && $past(acc_base_ea[15]) && ($past(acc_mode) inside {MODE_REG_OFFSET, MODE_MODULO, MODE_BIT_REV})
         |-> mem_effective_address[15];
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap mode left the window");
   property p_space; mem_valid |-> (mem_space == SPACE_BASE) == !mem_effective_address[15]; endproperty
   a_space: assert property (p_space) else $error("space and window bit disagree");
   property p_prog; mem_valid && mem_space == SPACE_PROG |-> !mem_write && mem_page[9]; endproperty
   a_prog: assert property (p_prog) else $error("bad program space access");
   property p_ext; mem_valid && mem_space == SPACE_EXT |-> mem_page != SEL_INVALID && !mem_page[9]; endproperty
   a_ext: assert property (p_ext) else $error("bad extended page issued");
endmodule

bind paged_data_window_address_extension paged_window_props props (.core_clk(core_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .acc_req(acc_req), .acc_is_write(acc_is_write), .acc_mode(acc_mode), .acc_base_ea(acc_base_ea),
   .acc_offset(acc_offset), .mem_valid(mem_valid), .mem_write(mem_write),
   .mem_effective_address(mem_effective_address), .mem_page(mem_page),
   .mem_space(mem_space), .addr_error_trap(addr_error_trap));

// [agen_model.sv]
// Purpose: Address generator model that issues accesses toward the window block.
// Assumes: Requests change just after a rising edge and hold until taken.
// Notes:   Idle address lines are inverted so stale values never look valid.
`timescale 1ns/100ps
module agen_model
   import paged_window_pkg::*;
(
   input wire logic core_clk,
   output logic acc_req,
   output logic acc_is_write,
   output addr_mode_t acc_mode,
   output logic [15:0] acc_base_ea,
   output logic [15:0] acc_offset
);
   // Quiet bus at time zero
   initial begin
      acc_req = 1'b0;
      acc_is_write = 1'b0;
      acc_mode = MODE_DIRECT;
      acc_base_ea = 16'h0000;
      acc_offset = 16'h0000;
   end
   // One request; the next call or idle releases it at the taking edge
   task automatic issue(input logic w, input addr_mode_t m, input logic [15:0] b, input logic [15:0] o);
      @(posedge core_clk);
      acc_req <= 1'b1;
      acc_is_write <= w;
      acc_mode <= m;
      acc_base_ea <= b;
      acc_offset <= o;
   endtask
   // Drop the request and scramble the released lines
   task automatic idle();
      @(posedge core_clk);
      acc_req <= 1'b0;
      acc_base_ea <= ~acc_base_ea;
      acc_offset <= ~acc_offset;
   endtask
endmodule

// [test_paged_data_window_address_extension.sv]
// Purpose: Self-checking bench for the paged data window address extension.
// Assumes: Register port and requests change just after rising edges.
// Notes:   Expected values come from the page boundary behaviour, never the design.
`timescale 1ns/100ps
module test_paged_data_window_address_extension
   import paged_window_pkg::*;
;
   logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic acc_req, acc_is_write, mem_valid, mem_write, addr_error_trap;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, acc_base_ea, acc_offset, mem_effective_address, rd;
   logic [9:0] mem_page;
   addr_mode_t acc_mode;
   space_t mem_space;
   int num_errors = 0, tests_run = 0, cycles = 0;
   paged_data_window_address_extension dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req),
      .acc_is_write(acc_is_write), .acc_mode(acc_mode), .acc_base_ea(acc_base_ea), .acc_offset(acc_offset),
      .mem_valid(mem_valid), .mem_write(mem_write), .mem_effective_address(mem_effective_address),
      .mem_page(mem_page), .mem_space(mem_space), .addr_error_trap(addr_error_trap));
   agen_model agen (.core_clk(core_clk), .acc_req(acc_req), .acc_is_write(acc_is_write), .acc_mode(acc_mode),
      .acc_base_ea(acc_base_ea), .acc_offset(acc_offset));
   // ==========================================================================
   // Clock and hang guard
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // Whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         summarize();
      end
   end
   // ==========================================================================
   // Shared tasks
   task automatic check(input string n, input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Program both selectors, issue one access, check result and both selectors
   task automatic run_vec(input logic w, input addr_mode_t m, input logic [9:0] rs, input logic [9:0] ws,
         input logic [15:0] b, input logic [15:0] o, input logic [15:0] ea, input logic [9:0] pg,
         input space_t sp, input logic tr);
      logic [15:0] v;
      reg_write(REG_RD_SEL, 16'(rs));
      reg_write(REG_WR_SEL, 16'(ws));
      agen.issue(w, m, b, o);
      agen.idle();
      #1 check("trap", 16'(addr_error_trap), 16'(tr));
      check("valid", 16'(mem_valid), 16'(!tr));
      if (!tr) begin
         check("ea", mem_effective_address, ea);
         check("page", 16'(mem_page), 16'(pg));
         check("space", 16'(mem_space), 16'(sp));
         check("dir", 16'(mem_write), 16'(w));
      end
      reg_read(w ? REG_WR_SEL : REG_RD_SEL, v);
      check("used_sel", v, 16'(tr ? (w ? ws : rs) : pg));
      reg_read(w ? REG_RD_SEL : REG_WR_SEL, v);
      check("other_sel", v, 16'(w ? rs : ws));
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========================================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      reg_read(REG_RD_SEL, rd);
      check("rd_sel_rst", rd, 16'(SEL_RESET));
      reg_read(REG_WR_SEL, rd);
      check("wr_sel_rst", rd, 16'(SEL_RESET));
      reg_write(REG_RD_SEL, 16'hFFFF);
      reg_read(REG_RD_SEL, rd);
      check("sel_width", rd, 16'h03FF);
      $display("test reset_and_width done");
      run_vec(1'b0, MODE_PRE_MOD, 10'h5, 10'h1, 16'h8000, 16'h2, 16'h8002, 10'h5, SPACE_EXT, 1'b0);
      run_vec(1'b0, MODE_POST_MOD, 10'h5, 10'h1, 16'hFFFE, 16'h2, 16'h8000, 10'h6, SPACE_EXT, 1'b0);
      run_vec(1'b1, MODE_PRE_MOD, 10'h5, 10'h10, 16'h8000, 16'hFFFE, 16'hFFFE, 10'hF, SPACE_EXT, 1'b0);
      run_vec(1'b0, MODE_REG_OFFSET, 10'h5, 10'h1, 16'hFFFE, 16'h4, 16'h8002, 10'h5, SPACE_EXT, 1'b0);
      run_vec(1'b1, MODE_MODULO, 10'h5, 10'h10, 16'h8000, 16'hFFFE, 16'hFFFE, 10'h10, SPACE_EXT, 1'b0);
      run_vec(1'b0, MODE_BIT_REV, 10'h5, 10'h1, 16'hFFFF, 16'h1, 16'h8000, 10'h5, SPACE_EXT, 1'b0);
      run_vec(1'b1, MODE_POST_MOD, 10'h5, 10'h1FF, 16'hFFFE, 16'h2, 16'h0, 10'h1FF, SPACE_BASE, 1'b0);
      run_vec(1'b0, MODE_PRE_MOD, 10'h1FF, 10'h1, 16'hFFFE, 16'h2, 16'h0, 10'h1FF, SPACE_BASE, 1'b0);
      run_vec(1'b0, MODE_PRE_MOD, 10'h2FF, 10'h1, 16'hFFFF, 16'h1, 16'h8000, 10'h300, SPACE_PROG, 1'b0);
      run_vec(1'b0, MODE_POST_MOD, 10'h3FF, 10'h1, 16'hFFFE, 16'h2, 16'h0, 10'h3FF, SPACE_BASE, 1'b0);
      run_vec(1'b0, MODE_PRE_MOD, 10'h1, 10'h1, 16'h8000, 16'hFFFE, 16'h7FFE, 10'h1, SPACE_BASE, 1'b0);
      run_vec(1'b0, MODE_PRE_MOD, 10'h200, 10'h1, 16'h8001, 16'hFFFE, 16'h7FFF, 10'h200, SPACE_BASE, 1'b0);
      run_vec(1'b0, MODE_PRE_MOD, 10'h300, 10'h1, 16'h8000, 16'hFFFE, 16'hFFFE, 10'h2FF, SPACE_PROG, 1'b0);
      run_vec(1'b0, MODE_PRE_MOD, 10'h5, 10'h1, 16'h7FFE, 16'h4, 16'h8002, 10'h5, SPACE_EXT, 1'b0);
      run_vec(1'b0, MODE_DIRECT, 10'h5, 10'h1, 16'hFFFE, 16'h2, 16'h0, 10'h5, SPACE_BASE, 1'b0);
      run_vec(1'b0, MODE_PRE_MOD, 10'h0, 10'h1, 16'h8000, 16'h0, 16'h0, 10'h0, SPACE_BASE, 1'b1);
      run_vec(1'b1, MODE_PRE_MOD, 10'h5, 10'h200, 16'h8004, 16'h0, 16'h0, 10'h0, SPACE_BASE, 1'b1);
      $display("test boundary_table done");
      reg_read(REG_STATUS, rd);
      check("sticky", rd, 16'h0003);
      reg_write(REG_STATUS, 16'h0003);
      reg_read(REG_STATUS, rd);
      check("sticky_clr", rd, 16'h0000);
      $display("test trap_status done");
      // Back to back: two read crossings, then a write on another page
      reg_write(REG_RD_SEL, 16'h02FF);
      reg_write(REG_WR_SEL, 16'h0020);
      agen.issue(1'b0, MODE_PRE_MOD, 16'hFFFF, 16'h0001);
      agen.issue(1'b0, MODE_POST_MOD, 16'hFFFE, 16'h0002);
      #1 check("burst_pg0", 16'(mem_page), 16'h0300);
      agen.issue(1'b1, MODE_PRE_MOD, 16'h8010, 16'h0000);
      #1 check("burst_pg1", 16'(mem_page), 16'h0301);
      agen.idle();
      #1 check("burst_wr_pg", 16'(mem_page), 16'h0020);
      check("burst_wr_ea", mem_effective_address, 16'h8010);
      reg_write(REG_LAST_EA, 16'h1234);
      reg_read(REG_LAST_EA, rd);
      check("last_ea_ro", rd, 16'h8010);
      $display("test burst done");
      summarize();
   end
endmodule
